// *** hw/rss_reset_sequencer.sv ***
// reset source sequencer: combines pin, undervoltage and watchdog resets,
// applies start delays and loads register initial values by reset type.
// assumes presetn is the power-on reset, config inputs are static fuses,
// and wdt_timeout/sleep_mode come from logic on pclk.
`timescale 1ns/100ps
`include "rss_params.svh"

module rss_reset_sequencer
    import rss_pkg::*;
#(
    parameter int POST_RELEASE_US = `RSS_POST_RELEASE_MS * 1000,
    parameter int BROWNOUT_MIN_NS = `RSS_BROWNOUT_MIN_NS,
    parameter int ADDR_W          = 12
) (
    // clock, reset, enable
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              clk_en,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // reset sources
    input  wire logic              ext_hw_clear_pin_n,
    input  wire logic              undervoltage_monitor,
    input  wire logic              wdt_timeout,
    input  wire logic              sleep_mode,
    input  wire rss_cfg_s          cfg,
    // core and peripheral controls
    output logic                   core_hold,
    output logic                   wdt_clear,
    output logic                   wdt_enable,
    output logic                   prescaler_clear,
    output logic [1:0]             uv_threshold,
    output rss_flags_s             flags,
    output rss_sfr_s               sfr
);

    // microsecond grain so a short delay can be set; whole ms would cost 200k cycles
    localparam int DELAY_CYC = POST_RELEASE_US * `RSS_CLK_MHZ;
    localparam int BROWN_CYC = (BROWNOUT_MIN_NS * `RSS_CLK_MHZ + 999) / 1000;
    localparam int DLY_W     = $clog2(DELAY_CYC + 1);
    localparam int UV_W      = $clog2(BROWN_CYC + 1);
    localparam int WAKE_RC   = `RSS_WAKE_RC_CYC;
    localparam int WAKE_XTAL = `RSS_WAKE_XTAL_CYC;

    // synchronisers: s1 feeds only s2
    logic [2:0] pin_sync_reg;
    logic [2:0] uv_sync_reg;
    logic       pin_low_reg;
    logic       uv_level_reg;
    logic [UV_W-1:0] uv_cnt_reg;

    // sequencer state
    rss_state_e       state_reg;
    rss_state_e       state_next;
    logic [DLY_W-1:0] cnt_reg;
    logic [DLY_W-1:0] cnt_next;
    rss_cause_e       cause_reg;
    rss_cause_e       cause_next;
    logic             full_apply;
    logic             sleep_apply;

    // outputs held in flops
    logic       pready_reg;
    logic [31:0] prdata_reg;
    logic       pslverr_reg;
    logic       core_hold_reg;
    logic       wdt_clear_reg;
    logic       wdt_enable_reg;
    logic       prescaler_clear_reg;
    logic [1:0] uv_threshold_reg;
    rss_flags_s flags_reg;
    rss_flags_s flags_next;
    rss_sfr_s   sfr_reg;

    // synchronised pin levels; a change counts once s2 and s3 agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sync_reg <= 3'h7;
            uv_sync_reg  <= 3'h0;
            pin_low_reg  <= 1'b0;
            uv_level_reg <= 1'b0;
        end else if (clk_en) begin
            pin_sync_reg <= {pin_sync_reg[1:0], ext_hw_clear_pin_n};
            uv_sync_reg  <= {uv_sync_reg[1:0], undervoltage_monitor};
            if (pin_sync_reg[1] == pin_sync_reg[2]) begin
                pin_low_reg <= ~pin_sync_reg[2];
            end
            if (uv_sync_reg[1] == uv_sync_reg[2]) begin
                uv_level_reg <= uv_sync_reg[2];
            end
        end
    end

    // undervoltage must outlast the minimum duration before it trips
    wire uv_armed = uv_level_reg & cfg.uv_enable;
    wire uv_trip  = (uv_cnt_reg == UV_W'(BROWN_CYC));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uv_cnt_reg <= '0;
        end else if (clk_en) begin
            if (!uv_armed) begin
                uv_cnt_reg <= '0;
            end else if (!uv_trip) begin
                uv_cnt_reg <= uv_cnt_reg + UV_W'(1);
            end
        end
    end

    // combined reset source and wait loads
    wire              hold_src  = pin_low_reg | uv_trip;
    wire [DLY_W-1:0]  dly_load  = DLY_W'(DELAY_CYC - 1);
    wire              fast_wake = cfg.osc_is_rc & cfg.rc_fast_wake;
    wire [DLY_W-1:0]  wake_load = fast_wake ? DLY_W'(WAKE_RC - 1)
                                            : DLY_W'(WAKE_XTAL - 1);

    // sequencer next state; pin and undervoltage win over everything
    always_comb begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        cause_next  = cause_reg;
        full_apply  = 1'b0;
        sleep_apply = 1'b0;
        if (hold_src) begin
            state_next = ST_HOLD;
            if (state_reg != ST_HOLD) begin
                full_apply = 1'b1;
                cause_next = pin_low_reg ? CAUSE_PIN : CAUSE_LVR;
            end
        end else begin
            unique case (state_reg)
                ST_RUN: begin
                    if (wdt_timeout && sleep_mode) begin
                        sleep_apply = 1'b1;
                        state_next  = ST_WAKE;
                        cnt_next    = wake_load;
                        cause_next  = CAUSE_WDT_SLEEP;
                    end else if (wdt_timeout) begin
                        full_apply  = 1'b1;
                        state_next  = ST_DELAY;
                        cnt_next    = dly_load;
                        cause_next  = CAUSE_WDT_RUN;
                    end
                end
                ST_HOLD: begin
                    state_next = ST_DELAY;
                    cnt_next   = dly_load;
                end
                ST_DELAY, ST_WAKE: begin
                    if (cnt_reg == '0) begin
                        state_next = ST_RUN;
                    end else begin
                        cnt_next = cnt_reg - DLY_W'(1);
                    end
                end
            endcase
        end
    end

    // power-on starts straight in the start delay with the cause recorded
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_DELAY;
            cnt_reg   <= DLY_W'(DELAY_CYC - 1);
            cause_reg <= CAUSE_POR;
        end else if (clk_en) begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            cause_reg <= cause_next;
        end
    end

    // apb decode; registered pready gives one wait state per access
    wire [ADDR_W-1:0] adr    = paddr;
    wire apb_fire = psel & penable & pready_reg;
    wire wr_fire  = apb_fire & pwrite;
    wire sel_st   = (adr == ADDR_W'(`RSS_OFF_STATUS));
    wire sel_sc   = (adr == ADDR_W'(`RSS_OFF_SCTL));
    wire sel_wp   = (adr == ADDR_W'(`RSS_OFF_WDPS));
    wire sel_tc   = (adr == ADDR_W'(`RSS_OFF_TIMER0_CONTROL));
    wire sel_ic   = (adr == ADDR_W'(`RSS_OFF_INTERRUPT_CONTROL_ZERO));
    wire sel_pd   = (adr == ADDR_W'(`RSS_OFF_PA_DATA));
    wire sel_pc   = (adr == ADDR_W'(`RSS_OFF_PA_DIR));
    wire sel_pw   = (adr == ADDR_W'(`RSS_OFF_PA_WAKE));
    wire sel_pp   = (adr == ADDR_W'(`RSS_OFF_PA_PULL));
    wire adr_hit  = sel_st | sel_sc | sel_wp | sel_tc | sel_ic |
                    sel_pd | sel_pc | sel_pw | sel_pp;

    // read mux; unimplemented bits read zero
    wire [31:0] st_word = {25'h0, cause_reg, 2'h0, flags_reg.powerdown_flag,
                           flags_reg.watchdog_expiry_flag};
    wire [31:0] rd_mux  =
        sel_st ? st_word :
        sel_sc ? {24'h0, sfr_reg.system_control_two} :
        sel_wp ? {29'h0, sfr_reg.watchdog_period_select} :
        sel_tc ? {24'h0, sfr_reg.timer0_control} :
        sel_ic ? {24'h0, sfr_reg.interrupt_control_zero} :
        sel_pd ? {24'h0, sfr_reg.port_a_data} :
        sel_pc ? {24'h0, sfr_reg.port_a_direction} :
        sel_pw ? {24'h0, sfr_reg.port_a_wake_enable} :
        sel_pp ? {24'h0, sfr_reg.port_a_pull_high} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h0;
            pslverr_reg <= 1'b0;
        end else if (clk_en) begin
            pready_reg  <= psel & penable & ~pready_reg;
            prdata_reg  <= (psel & penable & ~pready_reg & ~pwrite) ? rd_mux : 32'h0;
            pslverr_reg <= psel & penable & ~pready_reg & ~adr_hit;
        end
    end

    // flags: hardware set wins over a software clear in the same cycle
    wire sw_clr  = wr_fire & sel_st & pwdata[`RSS_ST_WR_CLEAR_BIT];
    wire sw_halt = wr_fire & sel_st & pwdata[`RSS_ST_WR_HALT_BIT];
    wire to_set  = sleep_apply | (full_apply & (cause_next == CAUSE_WDT_RUN));

    always_comb begin
        flags_next.watchdog_expiry_flag = to_set |
            (flags_reg.watchdog_expiry_flag & ~sw_clr);
        flags_next.powerdown_flag = sleep_apply | sw_halt |
            (flags_reg.powerdown_flag & ~sw_clr);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= '0;
        end else if (clk_en) begin
            flags_reg <= flags_next;
        end
    end

    // register file: reset load beats a software write; sleep expiry leaves all
    wire [7:0] wd8 = pwdata[7:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sfr_reg.system_control_two     <= `RSS_RST_SCTL;
            sfr_reg.watchdog_period_select <= `RSS_RST_WDPS;
            sfr_reg.timer0_control         <= `RSS_RST_TIMER0_CONTROL;
            sfr_reg.interrupt_control_zero <= `RSS_RST_INTERRUPT_CONTROL_ZERO;
            sfr_reg.port_a_data            <= `RSS_RST_PA_DATA;
            sfr_reg.port_a_direction       <= `RSS_RST_PA_DIR;
            sfr_reg.port_a_wake_enable     <= `RSS_RST_PA_WAKE;
            sfr_reg.port_a_pull_high       <= `RSS_RST_PA_PULL;
        end else if (clk_en) begin
            if (full_apply) begin
                sfr_reg.system_control_two     <= `RSS_RST_SCTL;
                sfr_reg.watchdog_period_select <= `RSS_RST_WDPS;
                sfr_reg.timer0_control         <= `RSS_RST_TIMER0_CONTROL;
                sfr_reg.interrupt_control_zero <= `RSS_RST_INTERRUPT_CONTROL_ZERO;
                sfr_reg.port_a_data            <= `RSS_RST_PA_DATA;
                sfr_reg.port_a_direction       <= `RSS_RST_PA_DIR;
                sfr_reg.port_a_wake_enable     <= `RSS_RST_PA_WAKE;
                sfr_reg.port_a_pull_high       <= `RSS_RST_PA_PULL;
            end else if (wr_fire) begin
                if (sel_sc) sfr_reg.system_control_two     <= wd8;
                if (sel_wp) sfr_reg.watchdog_period_select <= wd8[2:0];
                if (sel_tc) sfr_reg.timer0_control         <= wd8;
                if (sel_ic) sfr_reg.interrupt_control_zero <= wd8 & `RSS_MASK_7BIT;
                if (sel_pd) sfr_reg.port_a_data            <= wd8;
                if (sel_pc) sfr_reg.port_a_direction       <= wd8;
                if (sel_pw) sfr_reg.port_a_wake_enable     <= wd8;
                if (sel_pp) sfr_reg.port_a_pull_high       <= wd8 & `RSS_MASK_7BIT;
            end
        end
    end

    // core hold forces PC and SP to zero/top; watchdog and prescaler cleared on
    // every full reset, then released; the watchdog counts again at once only if cfg.wdt_cfg_enable is set
    wire wdt_on = cfg.wdt_cfg_enable |
                  (sfr_reg.system_control_two[3:0] != `RSS_WDT_OFF_CODE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_hold_reg       <= 1'b1;
            wdt_clear_reg       <= 1'b1;
            prescaler_clear_reg <= 1'b1;
            wdt_enable_reg      <= 1'b0;
            uv_threshold_reg    <= 2'h0;
        end else if (clk_en) begin
            core_hold_reg       <= (state_next != ST_RUN);
            wdt_clear_reg       <= full_apply;
            prescaler_clear_reg <= full_apply;
            wdt_enable_reg      <= wdt_on;
            uv_threshold_reg    <= cfg.uv_level;
        end
    end

    // output drive
    assign pready          = pready_reg;
    assign prdata          = prdata_reg;
    assign pslverr         = pslverr_reg;
    assign core_hold       = core_hold_reg;
    assign wdt_clear       = wdt_clear_reg;
    assign wdt_enable      = wdt_enable_reg;
    assign prescaler_clear = prescaler_clear_reg;
    assign uv_threshold    = uv_threshold_reg;
    assign flags           = flags_reg;
    assign sfr             = sfr_reg;

    // helper: cycles spent in the start delay
    int dly_len_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_len_reg <= 0;
        end else if (clk_en) begin
            dly_len_reg <= (state_next == ST_DELAY && state_reg == ST_DELAY)
                           ? dly_len_reg + 1 : 0;
        end
    end

    chk_pin_holds_core: assert property (
        @(posedge pclk) disable iff (!presetn || !clk_en)
        pin_low_reg |=> core_hold_reg && state_reg == ST_HOLD)
        else $error("pin reset did not hold the core");

    chk_delay_length: assert property (
        @(posedge pclk) disable iff (!presetn || !clk_en)
        (state_reg == ST_DELAY && state_next == ST_RUN && cause_reg != CAUSE_POR)
        |-> dly_len_reg == DELAY_CYC - 1)
        else $error("start delay length wrong");

    chk_uv_gated: assert property (
        @(posedge pclk) disable iff (!presetn || !clk_en)
        !cfg.uv_enable |-> !uv_trip)
        else $error("undervoltage tripped while disabled");

    chk_uv_filter: assert property (
        @(posedge pclk) disable iff (!presetn || !clk_en)
        $rose(uv_trip) |-> $past(uv_armed) && uv_armed)
        else $error("undervoltage tripped without persistence");

    chk_wdt_run_reset: assert property (
        @(posedge pclk) disable iff (!presetn || !clk_en)
        (state_reg == ST_RUN && wdt_timeout && !sleep_mode && !hold_src)
        |=> flags_reg.watchdog_expiry_flag && state_reg == ST_DELAY
            && sfr_reg.port_a_direction == `RSS_RST_PA_DIR)
        else $error("running watchdog expiry mishandled");

    chk_sleep_keeps_sfr: assert property (
        @(posedge pclk) disable iff (!presetn || !clk_en)
        sleep_apply && !wr_fire |=> $stable(sfr_reg) && core_hold_reg
            && flags_reg == 2'h3)
        else $error("sleep expiry disturbed registers");

    chk_wake_fast: assert property (
        @(posedge pclk) disable iff (!presetn || !clk_en)
        (sleep_apply && fast_wake) ##1 (!hold_src)[*2] |=> state_reg == ST_RUN)
        else $error("fast wake wait wrong");

    chk_wake_xtal: assert property (
        @(posedge pclk) disable iff (!presetn || !clk_en)
        (sleep_apply && !fast_wake) |=> ##126 state_reg == ST_WAKE)
        else $error("crystal wake wait too short");

    chk_pin_keeps_flags: assert property (
        @(posedge pclk) disable iff (!presetn || !clk_en)
        (full_apply && cause_next != CAUSE_WDT_RUN && !wr_fire)
        |=> $stable(flags_reg))
        else $error("pin or undervoltage reset changed flags");

    chk_set_wins: assert property (
        @(posedge pclk) disable iff (!presetn || !clk_en)
        (sleep_apply && sw_clr) |=> flags_reg.powerdown_flag
            && flags_reg.watchdog_expiry_flag)
        else $error("software clear beat hardware set");

    chk_wdt_enable: assert property (
        @(posedge pclk) disable iff (!presetn || !clk_en)
        (!cfg.wdt_cfg_enable && sfr_reg.system_control_two[3:0] == `RSS_WDT_OFF_CODE)
        ##1 $stable(cfg) |-> !wdt_enable_reg)
        else $error("watchdog enabled with off code");

endmodule : rss_reset_sequencer

// *** hw/rss_params.svh ***
// constants for the reset source sequencer: register offsets, reset values, timing
// assumes a 200 MHz pclk and a 32-bit APB with byte addresses
`ifndef RSS_PARAMS_SVH
`define RSS_PARAMS_SVH

// clock and timing
`define RSS_CLK_MHZ            200
`define RSS_POST_RELEASE_MS    50
`define RSS_BROWNOUT_MIN_NS    1000
`define RSS_WAKE_RC_CYC        2
`define RSS_WAKE_XTAL_CYC      128

// register byte offsets
`define RSS_OFF_STATUS         12'h000
`define RSS_OFF_SCTL           12'h004
`define RSS_OFF_WDPS           12'h008
`define RSS_OFF_TIMER0_CONTROL          12'h00c
`define RSS_OFF_INTERRUPT_CONTROL_ZERO          12'h010
`define RSS_OFF_PA_DATA        12'h014
`define RSS_OFF_PA_DIR         12'h018
`define RSS_OFF_PA_WAKE        12'h01c
`define RSS_OFF_PA_PULL        12'h020

// status field positions
`define RSS_ST_EXPIRY_BIT      0
`define RSS_ST_PDOWN_BIT       1
`define RSS_ST_CAUSE_LSB       4
`define RSS_ST_CAUSE_MSB       6
`define RSS_ST_WR_HALT_BIT     0
`define RSS_ST_WR_CLEAR_BIT    1

// reset values, write mask, watchdog off code and timer enable bit
`define RSS_RST_SCTL           8'h8a
`define RSS_RST_WDPS           3'h7
`define RSS_RST_TIMER0_CONTROL          8'h08
`define RSS_RST_INTERRUPT_CONTROL_ZERO          8'h00
`define RSS_RST_PA_DATA        8'hff
`define RSS_RST_PA_DIR         8'hff
`define RSS_RST_PA_WAKE        8'h00
`define RSS_RST_PA_PULL        8'h00
`define RSS_MASK_7BIT          8'h7f
`define RSS_WDT_OFF_CODE       4'ha
`define RSS_TMR_EN_BIT         4

`endif

// *** hw/rss_pkg.sv ***
// types shared by the reset source sequencer
// assumes nothing beyond a SystemVerilog compiler
package rss_pkg;

    typedef enum logic [1:0] {
        ST_RUN   = 2'h0,
        ST_HOLD  = 2'h1,
        ST_DELAY = 2'h3,
        ST_WAKE  = 2'h2
    } rss_state_e;

    typedef enum logic [2:0] {
        CAUSE_POR       = 3'h0,
        CAUSE_PIN       = 3'h1,
        CAUSE_LVR       = 3'h2,
        CAUSE_WDT_RUN   = 3'h3,
        CAUSE_WDT_SLEEP = 3'h4
    } rss_cause_e;

    // static configuration options
    typedef struct packed {
        logic       uv_enable;
        logic [1:0] uv_level;
        logic       osc_is_rc;
        logic       rc_fast_wake;
        logic       wdt_cfg_enable;
    } rss_cfg_s;

    // reset flags
    typedef struct packed {
        logic watchdog_expiry_flag;
        logic powerdown_flag;
    } rss_flags_s;

    // registers loaded by reset type
    typedef struct packed {
        logic [7:0] system_control_two;
        logic [2:0] watchdog_period_select;
        logic [7:0] timer0_control;
        logic [7:0] interrupt_control_zero;
        logic [7:0] port_a_data;
        logic [7:0] port_a_direction;
        logic [7:0] port_a_wake_enable;
        logic [7:0] port_a_pull_high;
    } rss_sfr_s;

endpackage : rss_pkg

// *** test/rss_pin_switch.sv ***
// partner model: push button or supervisor on the active-low external clear pin
// assumes pclk from the bench; the pin has a pull-up, so a released pin reads high
`timescale 1ns/100ps

module rss_pin_switch (
    // clock and command
    input  wire logic       pclk,
    input  wire logic       go,
    input  wire logic [7:0] len,
    // external clear pin
    output logic            pin_n
);
    int cnt = 0;

    // press for len cycles after each go; no bounce modelled, only clean presses
    always @(posedge pclk) begin
        if (go) begin
            cnt <= len;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end
    assign pin_n = (cnt == 0);
endmodule : rss_pin_switch

// *** test/rss_reset_sequencer_bench.sv ***
// self-checking bench for the reset source sequencer
// assumes the pin switch model and the design files are compiled first
`timescale 1ns/100ps

module rss_reset_sequencer_bench;
    import rss_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, er, pin_n, uvm = 0, wdt = 0, slp = 0, go = 0;
    logic core_hold, wdt_clear, wdt_enable, pre_clr;
    logic [1:0] uv_thr;
    rss_cfg_s cfg = '{1'b1, 2'h2, 1'b0, 1'b0, 1'b0};
    rss_flags_s flags;
    rss_sfr_s sfr;
    int err_total = 0, cmp_count = 0, n;
    // rows: {slverr, addr, write data, read back}
    logic [76:0] rows [10] = '{
        {1'b0, 12'h004, 32'h5a, 32'h5a}, {1'b0, 12'h008, 32'hf3, 32'h03},
        {1'b0, 12'h00c, 32'h15, 32'h15}, {1'b0, 12'h010, 32'hff, 32'h7f},
        {1'b0, 12'h014, 32'h3c, 32'h3c}, {1'b0, 12'h018, 32'h0f, 32'h0f},
        {1'b0, 12'h01c, 32'haa, 32'haa}, {1'b0, 12'h020, 32'hff, 32'h7f},
        {1'b1, 12'h024, 32'h77, 32'h00}, {1'b0, 12'h000, 32'h01, 32'h02}};
    localparam logic [58:0] SFR_POR = {8'h8a, 3'h7, 8'h08, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00};
    localparam logic [58:0] SFR_W   = {8'h5a, 3'h3, 8'h15, 8'h7f, 8'h3c, 8'h0f, 8'haa, 8'h7f};

    // 10 us start delay at 200 MHz is 2000 cycles
    rss_reset_sequencer #(.POST_RELEASE_US(10), .BROWNOUT_MIN_NS(20)) dut (.pclk(pclk),
        .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .ext_hw_clear_pin_n(pin_n), .undervoltage_monitor(uvm), .wdt_timeout(wdt),
        .sleep_mode(slp), .cfg(cfg), .core_hold(core_hold), .wdt_clear(wdt_clear),
        .wdt_enable(wdt_enable), .prescaler_clear(pre_clr), .uv_threshold(uv_thr),
        .flags(flags), .sfr(sfr));
    rss_pin_switch sw (.pclk(pclk), .go(go), .len(8'h0a), .pin_n(pin_n));

    // 200 MHz clock
    initial begin
        forever #2.5 pclk = ~pclk;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        if (err_total == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    // one apb transfer; waits for pready with a bound, releases after the sampling edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            err_total++;
            complete_run();
        end
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb

    // one-cycle watchdog pulse, then look just after the answering edge
    task automatic expire;
        @(posedge pclk);
        wdt <= 1;
        @(posedge pclk);
        wdt <= 0;
        #1;
    endtask : expire

    // count cycles until the core is let go; running out of bound ends the run
    task automatic wait_run(input int lim);
        n = 0;
        while (core_hold === 1'b1 && n < lim) begin
            @(posedge pclk);
            #1;
            n++;
        end
        if (n >= lim) begin
            err_total++;
            complete_run();
        end
    endtask : wait_run

    // main sequence
    initial begin
        repeat (5) @(posedge pclk);
        #1;
        check({flags, sfr}, {2'b00, SFR_POR});
        check({core_hold, wdt_clear, pre_clr, wdt_enable}, 4'he);
        presetn <= 1;
        wait_run(3000);
        check(n, 2000);
        for (int i = 0; i < 10; i++) begin
            apb(1, rows[i][75:64], rows[i][63:32]);
            apb(0, rows[i][75:64], 32'h0);
            check(rd, rows[i][31:0]);
            check(er, rows[i][76]);
        end
        check({uv_thr, wdt_enable}, {cfg.uv_level, 1'b0});
        slp <= 1;
        // crystal wake first, then the fast rc wake
        for (int f = 0; f < 2; f++) begin
            cfg.osc_is_rc <= f[0];
            cfg.rc_fast_wake <= f[0];
            expire();
            check({core_hold, flags, sfr}, {3'b111, SFR_W});
            wait_run(300);
            check(n, f ? 2 : 128);
        end
        // sleep expiry lands on the edge of a flag-clearing write
        fork
            apb(1, 12'h000, 32'h02);
            begin
                repeat (3) @(posedge pclk);
                wdt <= 1;
                @(posedge pclk);
                wdt <= 0;
            end
        join
        #1;
        check(flags, 2'b11);
        slp <= 0;
        apb(1, 12'h000, 32'h02);
        apb(1, 12'h000, 32'h01);
        expire();
        check({core_hold, wdt_clear, pre_clr, flags, sfr}, {5'h1f, SFR_POR});
        apb(1, 12'h004, 32'h55);
        apb(1, 12'h000, 32'h02);
        check(wdt_enable, 1'b1);
        apb(1, 12'h000, 32'h01);
        @(posedge pclk);
        go <= 1;
        @(posedge pclk);
        go <= 0;
        repeat (16) @(posedge pclk);
        apb(0, 12'h000, 32'h0);
        check({core_hold, flags, sfr}, {3'b101, SFR_POR});
        check(rd, 32'h12);
        // short episode, long episode with the option off, long episode with it on
        for (int p = 0; p < 3; p++) begin
            @(posedge pclk);
            cfg.uv_enable <= (p != 1);
            uvm <= 1;
            repeat (p ? 20 : 2) @(posedge pclk);
            uvm <= 0;
            repeat (8) @(posedge pclk);
            apb(0, 12'h000, 32'h0);
            check(rd, (p == 2) ? 32'h22 : 32'h12);
        end
        wait_run(3000);
        check({core_hold, wdt_enable}, 2'b00);
        complete_run();
    end
endmodule : rss_reset_sequencer_bench
